// [ptc_defines.svh]
// Register offsets, field positions and reset values of the timer pair block
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH

`define PTC_ADDR_W 8
`define PTC_NUM_TIMERS 4
`define PTC_TIMER_STRIDE 8'h10
`define PTC_CON_OFS 4'h0
`define PTC_COUNT_OFS 4'h4
`define PTC_PERIOD_OFS 4'h8
`define PTC_IRQ_STAT_OFS 8'h40
`define PTC_IRQ_MASK_OFS 8'h44

`define PTC_ON_BIT 15
`define PTC_IDLE_STOP_BIT 13
`define PTC_GATE_BIT 7
`define PTC_PS_HI 6
`define PTC_PS_LO 4
`define PTC_WIDE_BIT 3
`define PTC_CS_BIT 1

`define PTC_COUNT_RST 16'h0000
`define PTC_PERIOD_RST 16'hFFFF
`define PTC_MASK_RST 4'h0

`endif

// [ptc_pkg.sv]
// Types shared by the timer pair block
package ptc_pkg;
  `include "ptc_defines.svh"

  // Stored control fields of one timer
  typedef struct packed {
    logic on;
    logic idle_stop;
    logic gate_accumulate_enable;
    logic [2:0] input_prescale_select;
    logic wide_mode_select;
    logic clock_source_select;
  } ptc_con_t;

  typedef struct packed {
    logic [7:0] cnt;
  } ptc_pre_state_t;

  typedef struct packed {
    logic [`PTC_NUM_TIMERS-1:0] meta;
    logic [`PTC_NUM_TIMERS-1:0] stable;
    logic [`PTC_NUM_TIMERS-1:0] last;
  } ptc_sync_state_t;

  typedef struct packed {
    ptc_con_t [`PTC_NUM_TIMERS-1:0] con;
    logic [`PTC_NUM_TIMERS-1:0][15:0] count_value;
    logic [`PTC_NUM_TIMERS-1:0][15:0] period_value;
    logic [`PTC_NUM_TIMERS-1:0] stat;
    logic [`PTC_NUM_TIMERS-1:0] mask;
    logic [31:0] rdata;
    logic err;
    logic adc;
  } ptc_state_t;
endpackage

// [ptc_pin_sync.sv]
// Two-flop synchroniser and edge detect for the external count pins
`timescale 1ns/1ns
`include "ptc_defines.svh"
module ptc_pin_sync
  import ptc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`PTC_NUM_TIMERS-1:0] pin_in,
  output logic [`PTC_NUM_TIMERS-1:0] level,
  output logic [`PTC_NUM_TIMERS-1:0] rise,
  output logic [`PTC_NUM_TIMERS-1:0] fall
);
  ptc_sync_state_t s;
  ptc_sync_state_t next_s;

  // Meta stage feeds only the stable stage
  always_comb begin
    next_s = s;
    next_s.meta = pin_in;
    next_s.stable = s.meta;
    next_s.last = s.stable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Edges seen in the same cycle that the stable level changes
  assign level = s.stable;
  assign rise = s.stable & ~s.last;
  assign fall = ~s.stable & s.last;
endmodule

// [ptc_prescale.sv]
// Count clock prescaler, ratios 1 to 256
`timescale 1ns/1ns
`include "ptc_defines.svh"
module ptc_prescale
  import ptc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic count_in,
  input wire logic [2:0] ratio_sel,
  output logic tick
);
  ptc_pre_state_t s;
  ptc_pre_state_t next_s;
  logic [7:0] term;

  // Ratio code to last prescaler count
  function automatic logic [7:0] ptc_term(input logic [2:0] sel);
    case (sel)
      3'h0: ptc_term = 8'h00;
      3'h1: ptc_term = 8'h01;
      3'h2: ptc_term = 8'h03;
      3'h3: ptc_term = 8'h07;
      3'h4: ptc_term = 8'h0F;
      3'h5: ptc_term = 8'h1F;
      3'h6: ptc_term = 8'h3F;
      default: ptc_term = 8'hFF;
    endcase
  endfunction

  assign term = ptc_term(ratio_sel);
  // Greater-or-equal so a smaller ratio set mid-count cannot overrun
  assign tick = enable & count_in & (s.cnt >= term);

  always_comb begin
    next_s = s;
    if (!enable) begin
      next_s.cnt = 8'h00;
    end else if (count_in) begin
      if (s.cnt >= term) begin
        next_s.cnt = 8'h00;
      end else begin
        next_s.cnt = s.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// [ptc_timer_pair_ctrl.sv]
// Two timer pairs with APB registers, prescalers, gating and interrupts
`timescale 1ns/1ns
`include "ptc_defines.svh"
module ptc_timer_pair_ctrl
  import ptc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PTC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`PTC_NUM_TIMERS-1:0] external_count_pin,
  input wire logic device_idle,
  output logic irq,
  output logic adc_trigger
);
  localparam int NT = `PTC_NUM_TIMERS;

  // Register map in byte addresses, one 32-bit word each
  //   0x00 + 0x10*t: control of timer t
  //   0x04 + 0x10*t: count_value of timer t, bits 15:0
  //   0x08 + 0x10*t: period_value of timer t, bits 15:0
  //   0x0C + 0x10*t: hole, refused with slave error
  //   0x40: interrupt status, one bit per timer, write one to clear
  //   0x44: interrupt mask, same layout as status
  //   Any other word or a misaligned address is refused
  // Index t = 0..3 stands for the second to fifth timers
  // Index 0 pairs with 1 and 2 with 3

  ptc_state_t s;
  ptc_state_t next_s;

  logic [NT-1:0] pin_level;
  logic [NT-1:0] pin_rise;
  logic [NT-1:0] pin_fall;
  logic [NT-1:0] pre_en;
  logic [NT-1:0] pre_in;
  logic [NT-1:0][2:0] pre_ratio;
  logic [NT-1:0] tick;
  logic [NT-1:0] gated;

  // Both the count and gate roles of a pin go through one synchroniser.
  // Two flops then an edge flop: a pin edge acts three edges later,
  // and pulses shorter than two clocks may be lost.
  ptc_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(external_count_pin),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // One prescaler per timer; odd ones idle in 32-bit mode
  // Each keeps its own phase, so separate timers never share a divider
  for (genvar g = 0; g < NT; g++) begin : g_pre
    ptc_prescale u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .enable(pre_en[g]),
      .count_in(pre_in[g]),
      .ratio_sel(pre_ratio[g]),
      .tick(tick[g])
    );
  end

  // Step a count against its period: {match, next value}
  function automatic logic [32:0] ptc_step(input logic [31:0] v, input logic [31:0] p);
    if (v == p) begin
      ptc_step = {1'b1, 32'h0000_0000};
    end else begin
      ptc_step = {1'b0, v + 32'h0000_0001};
    end
  endfunction

  // Timer word decode from the low address bits, shared by writes and reads
  // 0 control, 1 count, 2 period, 3 hole
  function automatic logic [1:0] ptc_word(input logic [3:0] o);
    case (o)
      `PTC_CON_OFS: ptc_word = 2'h0;
      `PTC_COUNT_OFS: ptc_word = 2'h1;
      `PTC_PERIOD_OFS: ptc_word = 2'h2;
      default: ptc_word = 2'h3;
    endcase
  endfunction

  // Flag word decode: 0 status, 1 mask, 3 neither
  function automatic logic [1:0] ptc_flag_word(input logic [7:0] a);
    if (a == `PTC_IRQ_STAT_OFS) begin
      ptc_flag_word = 2'h0;
    end else if (a == `PTC_IRQ_MASK_OFS) begin
      ptc_flag_word = 2'h1;
    end else begin
      ptc_flag_word = 2'h3;
    end
  endfunction

  // Control register readback with unimplemented bits as zero
  function automatic logic [31:0] ptc_con_read(input ptc_con_t c);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`PTC_ON_BIT] = c.on;
    r[`PTC_IDLE_STOP_BIT] = c.idle_stop;
    // gate reads zero on external clock
    r[`PTC_GATE_BIT] = c.gate_accumulate_enable & ~c.clock_source_select;
    r[`PTC_PS_HI:`PTC_PS_LO] = c.input_prescale_select;
    r[`PTC_WIDE_BIT] = c.wide_mode_select;
    r[`PTC_CS_BIT] = c.clock_source_select;
    ptc_con_read = r;
  endfunction

  // Effective configuration of each timer's count clock
  always_comb begin
    int src;
    logic idle_hold;
    src = 0;
    idle_hold = 1'b0;
    pre_en = '0;
    pre_in = '0;
    pre_ratio = '0;
    gated = '0;
    for (int t = 0; t < NT; t++) begin
      // pairs are index 0 with 1, 2 with 3
      // odd timer in wide mode takes the even settings
      // Even partner found by clearing bit 0, so no index leaves the array
      src = t;
      if (s.con[t & ~1].wide_mode_select) begin
        src = t & ~1;
      end
      // idle stop halts the timer in idle
      // Idle input is on this clock already, so it needs no synchroniser
      if (s.con[src].wide_mode_select) begin
        // either idle stop bit halts a joined pair
        idle_hold = s.con[src].idle_stop | s.con[src | 1].idle_stop;
      end else begin
        idle_hold = s.con[t].idle_stop;
      end
      if (src == t) begin
        pre_en[t] = s.con[t].on & ~(device_idle & idle_hold);
      end else begin
        pre_en[t] = 1'b0;
      end
      // Odd timer in wide mode copies the even ratio but stays disabled
      pre_ratio[t] = s.con[src].input_prescale_select;
      if (s.con[src].clock_source_select) begin
        pre_in[t] = pin_rise[src];
      // gate applies only on the internal clock
      end else if (s.con[src].gate_accumulate_enable) begin
        // counts only while gate is high
        pre_in[t] = pin_level[src];
        // Falling-edge flag only while the timer runs
        gated[t] = pre_en[t];
      end else begin
        pre_in[t] = 1'b1;
      end
    end
  end

  // Next-state logic: counting, flags and the register port
  always_comb begin
    logic [32:0] step;
    logic [NT-1:0] hit;
    logic [NT-1:0] clr;
    logic [3:0] ti;
    logic [3:0] ofs;
    logic in_timers;
    logic wr;
    ptc_con_t wc;
    step = '0;
    hit = '0;
    clr = '0;
    // Timer index and word offset taken straight from the address
    ti = {2'b00, paddr[5:4]};
    ofs = paddr[3:0];
    in_timers = (paddr[7:6] == 2'b00);
    // Writes act only at the access edge
    wr = psel & penable & pwrite;
    wc = '0;
    next_s = s;
    next_s.adc = 1'b0;

    // Counting per pair. A period match at edge n zeroes the count and
    // registers the flag and the converter trigger at that same edge;
    // the trigger stands for one cycle only.
    for (int p = 0; p < NT / 2; p++) begin
      if (s.con[2*p].wide_mode_select) begin
        if (tick[2*p]) begin
          // even is low half, odd high half
          step = ptc_step({s.count_value[2*p+1], s.count_value[2*p]},
                          {s.period_value[2*p+1], s.period_value[2*p]});
          next_s.count_value[2*p] = step[15:0];
          next_s.count_value[2*p+1] = step[31:16];
          // joined match lands on the odd flag
          hit[2*p+1] = step[32];
        end
      end else begin
        for (int k = 0; k < 2; k++) begin
          if (tick[2*p+k]) begin
            // wrap to zero after matching period
            step = ptc_step({16'h0000, s.count_value[2*p+k]},
                            {16'h0000, s.period_value[2*p+k]});
            next_s.count_value[2*p+k] = step[15:0];
            hit[2*p+k] = step[32];
          end
        end
      end
    end

    // converter trigger from the third timer match
    next_s.adc = hit[1];

    // gate falling edge flags the timer
    for (int t = 0; t < NT; t++) begin
      if (gated[t] && pin_fall[t]) begin
        if (!t[0] && s.con[t].wide_mode_select) begin
          hit[t | 1] = 1'b1;
        end else begin
          hit[t] = 1'b1;
        end
      end
    end

    // Register writes; a data write overrides counting in that cycle
    // Software writing a running count gives up that cycle's tick
    if (wr && in_timers && paddr[1:0] == 2'b00) begin
      case (ptc_word(ofs))
        2'h0: begin
          wc.on = pwdata[`PTC_ON_BIT];
          wc.idle_stop = pwdata[`PTC_IDLE_STOP_BIT];
          wc.gate_accumulate_enable = pwdata[`PTC_GATE_BIT];
          wc.input_prescale_select = pwdata[`PTC_PS_HI:`PTC_PS_LO];
          // odd timers keep no wide bit
          wc.wide_mode_select = pwdata[`PTC_WIDE_BIT] & ~ti[0];
          wc.clock_source_select = pwdata[`PTC_CS_BIT];
          next_s.con[ti[1:0]] = wc;
        end
        2'h1: begin
          next_s.count_value[ti[1:0]] = pwdata[15:0];
        end
        2'h2: begin
          next_s.period_value[ti[1:0]] = pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
    if (wr && ptc_flag_word(paddr) == 2'h0) begin
      clr = pwdata[NT-1:0];
    end
    if (wr && ptc_flag_word(paddr) == 2'h1) begin
      next_s.mask = pwdata[NT-1:0];
    end

    // Set beats a same-cycle write-one clear,
    // so an event on the clearing edge is never lost
    next_s.stat = (s.stat & ~clr) | hit;

    // Read data captured in the setup phase, shown in the access phase
    // Registered read data keeps prdata steady through the access cycle
    if (psel && !penable) begin
      next_s.rdata = 32'h0000_0000;
      next_s.err = 1'b0;
      if (paddr[1:0] != 2'b00) begin
        next_s.err = 1'b1;
      end else if (in_timers) begin
        case (ptc_word(ofs))
          2'h0: begin
            next_s.rdata = ptc_con_read(s.con[ti[1:0]]);
          end
          2'h1: begin
            next_s.rdata = {16'h0000, s.count_value[ti[1:0]]};
          end
          2'h2: begin
            next_s.rdata = {16'h0000, s.period_value[ti[1:0]]};
          end
          default: begin
            next_s.err = 1'b1;
          end
        endcase
      end else if (ptc_flag_word(paddr) == 2'h0) begin
        next_s.rdata = {28'h0000000, s.stat};
      end else if (ptc_flag_word(paddr) == 2'h1) begin
        next_s.rdata = {28'h0000000, s.mask};
      end else begin
        next_s.err = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.con <= '0;
      s.count_value <= {NT{`PTC_COUNT_RST}};
      s.period_value <= {NT{`PTC_PERIOD_RST}};
      s.stat <= '0;
      s.mask <= `PTC_MASK_RST;
      s.rdata <= 32'h0000_0000;
      s.err <= 1'b0;
      s.adc <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Zero wait states: every access finishes in its first access cycle
  assign pready = psel & penable;
  // Error decided at setup, shown only in the access cycle
  assign pslverr = psel & penable & s.err;
  assign prdata = s.rdata;
  // Level interrupt from registered flags, so no glitch on a mask write
  assign irq = |(s.stat & s.mask);
  // Converter trigger is a registered one-cycle pulse
  assign adc_trigger = s.adc;
endmodule

// [ptc_checker.sv]
// Port-level assertion checker for the timer pair block
`timescale 1ns/1ns
module ptc_checker
  import ptc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] external_count_pin,
  input wire logic device_idle,
  input wire logic irq,
  input wire logic adc_trigger
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase and control-register read decode
  wire logic acc = psel && penable;
  wire logic con_rd = acc && !pwrite && paddr < 8'h40 && paddr[3:0] == 4'h0;

  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  property p_idle; !psel |-> !pready && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("bus answer while idle");
  property p_misalign; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
  property p_hole; acc && paddr == 8'h48 |-> pslverr && prdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("unmapped access accepted");
  property p_stat_ok; acc && paddr == 8'h40 |-> !pslverr; endproperty
  a_stat_ok: assert property (p_stat_ok) else $error("status access refused");
  property p_con_zero; con_rd |-> (prdata & 32'hFFFF5F05) == 32'h0; endproperty
  a_con_zero: assert property (p_con_zero) else $error("reserved bit set");
  property p_odd_wide; con_rd && paddr[4] |-> !prdata[3]; endproperty
  a_odd_wide: assert property (p_odd_wide) else $error("wide bit on odd timer");
  property p_ext_gate; con_rd && prdata[1] |-> !prdata[7]; endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("gate visible with pin clock");
  property p_mask_off; acc && pwrite && paddr == 8'h44 && pwdata[3:0] == 4'h0 |=> !irq[*2];
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with all masked");
  c_irq: cover property ($rose(irq));
  c_adc: cover property (adc_trigger);
  c_err: cover property (pslverr);
endmodule

bind ptc_timer_pair_ctrl ptc_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .external_count_pin, .device_idle, .irq, .adc_trigger);

// [ptc_pin_model.sv]
// Behavioural source for the external count and gate pins
`timescale 1ns/1ns
module ptc_pin_model (
  input wire logic pclk,
  input wire logic start,
  input wire logic [1:0] idx,
  input wire logic [7:0] num,
  input wire logic [7:0] wid,
  output logic [3:0] pins,
  output logic busy
);
  initial begin
    pins = 4'h0;
    busy = 1'b0;
  end
  // count pulses or one gate window
  // Widths of two clocks or more, shorter ones may be lost in sync
  always begin
    @(posedge pclk);
    if (start) begin
      busy <= 1'b1;
      repeat (num) begin
        pins[idx] <= 1'b1;
        repeat (wid) @(posedge pclk);
        pins[idx] <= 1'b0;
        repeat (wid) @(posedge pclk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// [tb.sv]
// Self-checking bench for the timer pair block
`timescale 1ns/1ns
module tb;
  import ptc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic device_idle = 1'b0, start = 1'b0, pready, pslverr, irq, adc_trigger, busy, err;
  logic [7:0] paddr = 8'h00, num = 8'h00, wid = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, prev;
  logic [3:0] pins;
  logic [1:0] idx = 2'h0;
  int miscompares = 0, total_checks = 0, adc_n = 0, v;
  // 250 MHz clock and trigger pulse count
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (adc_trigger === 1'b1) adc_n <= adc_n + 1;
  ptc_timer_pair_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .external_count_pin(pins), .device_idle, .irq, .adc_trigger);
  ptc_pin_model pm (.pclk, .start, .idx, .num, .wid, .pins, .busy);
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic ok(input string nm, input logic c);
    chk(nm, 32'h1, {31'h0, c});
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask
  // Hand pins to the model and wait, bounded, until it is done
  task automatic pulse(input logic [1:0] i, input logic [7:0] n, input logic [7:0] w);
    int k;
    k = 0;
    idx <= i;
    num <= n;
    wid <= w;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    do begin
      @(posedge pclk);
      k++;
    end while (busy !== 1'b0 && k < 2000);
    ok("pin model done", busy === 1'b0);
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc("con0 reset", 8'h00, 32'h0);
    rdc("period reset", 8'h08, 32'hFFFF);
    rdc("status reset", 8'h40, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rdc("con0 all ones", 8'h00, 32'h0000A07A);
    wr(8'h10, 32'hFFFFFFFF);
    rdc("con1 all ones", 8'h10, 32'h0000A072);
    wr(8'h00, 32'h80);
    rdc("gate stored", 8'h00, 32'h80);
    wr(8'h10, 32'h0);
    // Each ratio over 514 clocks, two counts of slack each way
    for (int p = 0; p < 8; p++) begin
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h8000 | (p << 4));
      repeat (512) @(posedge pclk);
      wr(8'h00, 32'h0);
      bus(1'b0, 8'h04, 32'h0);
      v = 514 / (p == 7 ? 256 : 1 << p);
      ok("prescale count", rd + 2 >= v && rd <= v + 2);
    end
    device_idle <= 1'b1;
    wr(8'h00, 32'hA000);
    bus(1'b0, 8'h04, 32'h0);
    prev = rd;
    rdc("idle stopped", 8'h04, prev);
    wr(8'h00, 32'h8000);
    bus(1'b0, 8'h04, 32'h0);
    ok("idle running", rd > prev);
    device_idle <= 1'b0;
    wr(8'h00, 32'h0);
    wr(8'h18, 32'h4);
    wr(8'h14, 32'h0);
    wr(8'h44, 32'h2);
    wr(8'h10, 32'h8000);
    v = 0;
    while (irq !== 1'b1 && v < 200) begin
      @(posedge pclk);
      v++;
    end
    wr(8'h10, 32'h0);
    rdc("wrap flag", 8'h40, 32'h2);
    ok("trigger pulsed", adc_n > 0);
    bus(1'b0, 8'h14, 32'h0);
    ok("wraps at period", rd <= 32'h4);
    wr(8'h40, 32'h2);
    rdc("flag cleared", 8'h40, 32'h0);
    ok("irq cleared", irq === 1'b0);
    wr(8'h08, 32'h5);
    wr(8'h18, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h0012); // odd idle stop kept clear
    wr(8'h00, 32'h8008);
    repeat (30) @(posedge pclk);
    wr(8'h00, 32'h0);
    rdc("wide flag on odd", 8'h40, 32'h2);
    wr(8'h40, 32'hF);
    wr(8'h04, 32'hFFFE);
    wr(8'h08, 32'hFFFF);
    wr(8'h18, 32'h1);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h8008);
    repeat (6) @(posedge pclk);
    wr(8'h00, 32'h0);
    rdc("carry to odd", 8'h14, 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h24, 32'h0);
    wr(8'h20, 32'h8002);
    pulse(2'h2, 8'h05, 8'h03);
    repeat (6) @(posedge pclk);
    rdc("pin counts", 8'h24, 32'h5);
    wr(8'h20, 32'h0);
    wr(8'h34, 32'h0);
    wr(8'h30, 32'h8080);
    pulse(2'h3, 8'h01, 8'h28);
    wr(8'h30, 32'h0);
    bus(1'b0, 8'h34, 32'h0);
    ok("gated count", rd + 3 >= 32'd40 && rd <= 32'd43);
    rdc("gate fall flag", 8'h40, 32'h8);
    wr(8'h44, 32'h8);
    @(negedge pclk);
    ok("irq unmasked", irq === 1'b1);
    wr(8'h44, 32'h0);
    @(negedge pclk);
    ok("irq masked", irq === 1'b0);
    wr(8'h40, 32'hF);
    rdc("unmapped data", 8'h48, 32'h0);
    ok("unmapped refused", err === 1'b1);
    bus(1'b0, 8'h0C, 32'h0);
    ok("hole refused", err === 1'b1);
    // Mid-run reset returns control and period to reset values
    wr(8'h00, 32'h8000);
    wr(8'h38, 32'h7);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("con0 after reset", 8'h00, 32'h0);
    rdc("period after reset", 8'h38, 32'hFFFF);
    final_report();
  end
endmodule
